// ==== hw/sic_pkg.sv ====
package sic_pkg;

	// ==========================================================
	// register offsets (15-bit addressing)
	localparam logic [14:0] OFS_CFG_B = 15'h0001;
	localparam logic [14:0] OFS_MAKER_LO = 15'h000c;
	localparam logic [14:0] OFS_MAKER_HI = 15'h000d;
	localparam logic [14:0] OFS_WRAP = 15'h000e;
	localparam logic [14:0] OFS_CTRL = 15'h0010;
	localparam logic [14:0] OFS_FLAGS = 15'h0011;
	localparam logic [14:0] OFS_STATUS = 15'h0014;
	localparam logic [14:0] ADDR_MAX = 15'h017f;
	localparam logic [14:0] MB_FIRST = 15'h0060;
	localparam logic [14:0] MB_LAST = 15'h00df;

	// ==========================================================
	// identity (value is arbitrary)
	localparam logic [15:0] MAKER_CODE = 16'h5a3c;

	// ==========================================================
	// field positions
	localparam int B_STYLE = 7;
	localparam int CRC_EN_MSB = 7;
	localparam int CRC_EN_LSB = 6;
	localparam int B_WHOLE = 5;
	localparam int CRC_N_MSB = 1;
	localparam int CRC_N_LSB = 0;
	localparam int F_NOT_RDY = 7;
	localparam int F_SCK = 4;
	localparam int F_CRC = 3;
	localparam int F_WR_RO = 2;
	localparam int F_PART = 1;
	localparam int F_ADDR = 0;
	localparam int S_IFERR = 2;

	// ==========================================================
	// reset values, masks, encodings
	localparam logic CFG_B_RST = 1'b0;
	localparam logic [7:0] WRAP_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h23;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'he3;
	localparam logic [7:0] FLAGS_W1C = 8'h8f;
	localparam logic [7:0] FLAGS_RW = 8'h10;
	localparam logic [1:0] CRC_EN_ON = 2'h1;
	localparam logic [1:0] CRC_N_ON = 2'h2;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int READY_TIME_NS = 1000;
	localparam logic [7:0] READY_CYC = 8'((READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========================================================
	// protocol states
	typedef enum logic [2:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_CHK, ST_DROP} sic_state_e;

	function automatic logic [7:0] sic_crc8(input logic [7:0] d);
		logic [7:0] c;
		c = CRC_INIT ^ d;
		for (int i = 0; i < 8; i++)
		begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	function automatic logic sic_is_ro(input logic [14:0] a);
		return (a == OFS_MAKER_LO) || (a == OFS_MAKER_HI) || (a == OFS_STATUS);
	endfunction

	function automatic logic sic_is_mb(input logic [14:0] a);
		return (a >= MB_FIRST) && (a <= MB_LAST);
	endfunction

endpackage

// ==== hw/sic_frame_if.sv ====
`timescale 1ns/10ps
// ==========================================================
// frame events from the pin front end
interface sic_frame_if;
	logic frame_start;
	logic frame_end;
	logic bit_valid;
	logic bit_val;
	modport front (output frame_start, output frame_end, output bit_valid, output bit_val);
	modport core (input frame_start, input frame_end, input bit_valid, input bit_val);
endinterface

// ==== hw/sic_pin_sync.sv ====
`timescale 1ns/10ps
module sic_pin_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// serial pins
	input wire logic sck,
	input wire logic cs_b,
	input wire logic sdi,
	// events
	sic_frame_if.front f
);
	// ==========================================================
	// two-stage synchronisers, then one stage for edges
	logic [1:0] sck_r;
	logic [1:0] cs_r;
	logic [1:0] sdi_r;
	logic sck_prev_r;
	logic cs_prev_r;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sck_r <= 2'h0;
			cs_r <= 2'h3;
			sdi_r <= 2'h0;
			sck_prev_r <= 1'b0;
			cs_prev_r <= 1'b1;
		end
		else
		begin
			sck_r <= {sck_r[0], sck};
			cs_r <= {cs_r[0], cs_b};
			sdi_r <= {sdi_r[0], sdi};
			sck_prev_r <= sck_r[1];
			cs_prev_r <= cs_r[1];
		end
	end

	// sdi shares the sck latency, so the sampled bit lines up with the rise
	assign f.frame_start = cs_prev_r && !cs_r[1];
	assign f.frame_end = !cs_prev_r && cs_r[1];
	assign f.bit_valid = !cs_r[1] && sck_r[1] && !sck_prev_r;
	assign f.bit_val = sdi_r[1];
endmodule

// ==== hw/sic_config_status.sv ====
`timescale 1ns/10ps
// ==========================================================
// Summary of operation
// R1 - wrap count zero: streaming addresses keep advancing, no looping
// R2 - wrap count nonzero: after that many registers, return to start address
// R3 - checksum active only when enable is 1 and inverted enable is 2
// R4 - whole-register access: all bytes of a wide register in one data phase
// R5 - frame started before interface ready sets not-ready flag, write one clears
// R6 - frame with wrong number of clock edges sets clock count flag
// R7 - checksum mismatch sets flag, only while checksum active, write one clears
// R8 - write to an all read-only register sets flag, write one clears
// R9 - partial wide register access sets flag while whole access set
// R10 - access outside address range sets flag, write one clears
// R11 - fixed 16-bit maker code, upper byte readable at its own register
// R12 - reset: enable 0, whole access 1, inverted enable 3, checksum off
// R13 - style bit clear selects streaming, set selects single instruction
// R14 - status summary bit is the OR of all interface error flags
// R15 - reserved bits read zero, writes to them ignored
module sic_config_status (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// serial link
	input wire logic sck,
	input wire logic cs_b,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	// status
	output logic interface_error
);
	import sic_pkg::*;

	sic_frame_if f ();

	sic_pin_sync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.sck(sck),
		.cs_b(cs_b),
		.sdi(sdi),
		.f(f)
	);

	// ==========================================================
	// state
	sic_state_e state_r, state_nxt;
	logic [3:0] icnt_r, icnt_nxt;
	logic [2:0] bcnt_r, bcnt_nxt;
	logic [15:0] sh_r;
	logic rw_r, rw_nxt;
	logic [14:0] addr_r, addr_nxt;
	logic [14:0] start_r, start_nxt;
	logic [7:0] idx_r, idx_nxt;
	logic [7:0] held_r, held_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic sdo_r, sdo_nxt;
	logic oe_r, oe_nxt;
	logic mb_pend_r, mb_pend_nxt;
	logic [14:0] mb_addr_r, mb_addr_nxt;
	logic style_r, style_nxt;
	logic [7:0] wrap_r, wrap_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic [7:0] rdy_cnt_r;
	logic ready_r;
	logic interr_r;
	logic [7:0] rd_data;

	// ==========================================================
	// decode
	wire [15:0] sh_in = {sh_r[14:0], f.bit_val};
	wire [14:0] in_addr = sh_in[14:0];
	wire in_rw = sh_in[15];
	wire in_byte = (state_r == ST_DATA) || (state_r == ST_CHK);
	wire instr_done = (state_r == ST_INSTR) && f.bit_valid && (icnt_r == 4'hf);
	wire byte_done = in_byte && f.bit_valid && (bcnt_r == 3'h7);
	wire data_done = byte_done && (state_r == ST_DATA);
	wire chk_done = byte_done && (state_r == ST_CHK);
	wire crc_on = (ctrl_r[CRC_EN_MSB:CRC_EN_LSB] == CRC_EN_ON)
		&& (ctrl_r[CRC_N_MSB:CRC_N_LSB] == CRC_N_ON); // [R3]
	wire strict = ctrl_r[B_WHOLE];
	wire [7:0] crc_exp = sic_crc8(held_r);
	wire crc_match = sh_in[7:0] == crc_exp;
	wire adv = (data_done && !crc_on) || chk_done;
	wire wr_commit = !rw_r && ((data_done && !crc_on) || (chk_done && crc_match));
	wire [7:0] wdata = (state_r == ST_CHK) ? held_r : sh_in[7:0];
	wire wrap_hit = (wrap_r != 8'h00) && ((idx_r + 8'h01) == wrap_r); // [R1] [R2]
	wire [14:0] addr_step = wrap_hit ? start_r : (addr_r + 15'h0001); // [R2]
	wire [7:0] idx_step = wrap_hit ? 8'h00 : (idx_r + 8'h01);
	wire [14:0] load_addr = instr_done ? in_addr : addr_step;
	wire wr_flags = wr_commit && (addr_r == OFS_FLAGS);

	// ==========================================================
	// error events
	wire err_early = f.frame_start && !ready_r; // [R5]
	wire err_sck = f.frame_end && (((state_r == ST_INSTR) && (icnt_r != 4'h0))
		|| ((state_r == ST_DATA) && (bcnt_r != 3'h0)) || (state_r == ST_CHK)); // [R6]
	wire err_crc = chk_done && !rw_r && crc_on && !crc_match; // [R7]
	wire err_ro = wr_commit && sic_is_ro(addr_r); // [R8]
	// a wide register needs its even byte then its odd byte in one data phase
	wire pend_ok = mb_pend_r && (addr_r == (mb_addr_r + 15'h0001)); // [R4]
	wire err_part = strict && ((adv && ((mb_pend_r && !pend_ok)
		|| (sic_is_mb(addr_r) && addr_r[0] && !pend_ok)))
		|| ((instr_done || f.frame_end) && mb_pend_r)); // [R9]
	wire err_addr = (instr_done && (in_addr > ADDR_MAX)) || (adv && (addr_r > ADDR_MAX)); // [R10]
	wire [7:0] set_vec = {err_early, 2'b00, err_sck, err_crc, err_ro, err_part, err_addr};
	wire [7:0] w1c_clr = wr_flags ? (wdata & FLAGS_W1C) : 8'h00;
	wire [7:0] rw_keep = wr_flags ? ~FLAGS_RW : 8'hff;
	wire [7:0] rw_set = wr_flags ? (wdata & FLAGS_RW) : 8'h00;

	// set wins over a clear in the same cycle
	assign flags_nxt = ((flags_r & ~w1c_clr & rw_keep) | rw_set) | set_vec; // [R5] [R7] [R8] [R10]

	// ==========================================================
	// register writes; reserved bits are masked off
	assign style_nxt = (wr_commit && (addr_r == OFS_CFG_B)) ? wdata[B_STYLE] : style_r; // [R13]
	assign wrap_nxt = (wr_commit && (addr_r == OFS_WRAP)) ? wdata : wrap_r;
	assign ctrl_nxt = (wr_commit && (addr_r == OFS_CTRL)) ? (wdata & CTRL_WMASK) : ctrl_r; // [R15]

	// ==========================================================
	// read mux; unimplemented in-range addresses read zero
	always_comb
	begin
		rd_data = 8'h00;
		unique case (load_addr)
			OFS_CFG_B: rd_data = {style_r, 7'h00}; // [R15]
			OFS_MAKER_LO: rd_data = MAKER_CODE[7:0];
			OFS_MAKER_HI: rd_data = MAKER_CODE[15:8]; // [R11]
			OFS_WRAP: rd_data = wrap_r;
			OFS_CTRL: rd_data = ctrl_r;
			OFS_FLAGS: rd_data = flags_r;
			OFS_STATUS: rd_data = {5'h00, |flags_r, 2'h0}; // [R14]
			default: rd_data = 8'h00;
		endcase
	end

	// ==========================================================
	// frame sequencing
	always_comb
	begin
		state_nxt = state_r;
		icnt_nxt = icnt_r;
		bcnt_nxt = bcnt_r;
		rw_nxt = rw_r;
		addr_nxt = addr_r;
		start_nxt = start_r;
		idx_nxt = idx_r;
		held_nxt = held_r;
		tx_nxt = tx_r;
		sdo_nxt = sdo_r;
		oe_nxt = oe_r;
		mb_pend_nxt = mb_pend_r;
		mb_addr_nxt = mb_addr_r;
		if (f.bit_valid && (state_r == ST_INSTR))
			icnt_nxt = icnt_r + 4'h1;
		if (f.bit_valid && in_byte)
			bcnt_nxt = bcnt_r + 3'h1;
		if (f.bit_valid && in_byte && rw_r)
		begin
			sdo_nxt = tx_r[7];
			tx_nxt = {tx_r[6:0], 1'b0};
		end
		if (f.frame_start)
		begin
			state_nxt = ready_r ? ST_INSTR : ST_DROP; // [R5]
			icnt_nxt = 4'h0;
			bcnt_nxt = 3'h0;
			mb_pend_nxt = 1'b0;
		end
		if (instr_done)
		begin
			state_nxt = ST_DATA;
			rw_nxt = in_rw;
			addr_nxt = in_addr;
			start_nxt = in_addr;
			idx_nxt = 8'h00;
			mb_pend_nxt = 1'b0;
			if (in_rw)
			begin
				held_nxt = rd_data;
				sdo_nxt = rd_data[7];
				tx_nxt = {rd_data[6:0], 1'b0};
				oe_nxt = 1'b1;
			end
		end
		if (data_done)
		begin
			if (!rw_r)
				held_nxt = sh_in[7:0];
			if (crc_on)
			begin
				state_nxt = ST_CHK;
				if (rw_r)
				begin
					sdo_nxt = crc_exp[7];
					tx_nxt = {crc_exp[6:0], 1'b0};
				end
			end
		end
		if (adv)
		begin
			mb_pend_nxt = strict && sic_is_mb(addr_r) && !addr_r[0]; // [R4]
			mb_addr_nxt = addr_r;
			if (style_r)
			begin
				state_nxt = ST_INSTR; // [R13]
				icnt_nxt = 4'h0;
				oe_nxt = 1'b0;
				sdo_nxt = 1'b0;
			end
			else
			begin
				state_nxt = ST_DATA;
				addr_nxt = addr_step; // [R1] [R2]
				idx_nxt = idx_step;
				if (rw_r)
				begin
					held_nxt = rd_data;
					sdo_nxt = rd_data[7];
					tx_nxt = {rd_data[6:0], 1'b0};
				end
			end
		end
		if (f.frame_end)
		begin
			state_nxt = ST_IDLE;
			oe_nxt = 1'b0;
			sdo_nxt = 1'b0;
			mb_pend_nxt = 1'b0;
		end
	end

	// ==========================================================
	// flops
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= ST_IDLE;
			icnt_r <= 4'h0;
			bcnt_r <= 3'h0;
			sh_r <= 16'h0000;
			rw_r <= 1'b0;
			addr_r <= 15'h0000;
			start_r <= 15'h0000;
			idx_r <= 8'h00;
			held_r <= 8'h00;
			tx_r <= 8'h00;
			sdo_r <= 1'b0;
			oe_r <= 1'b0;
			mb_pend_r <= 1'b0;
			mb_addr_r <= 15'h0000;
		end
		else
		begin
			state_r <= state_nxt;
			icnt_r <= icnt_nxt;
			bcnt_r <= bcnt_nxt;
			sh_r <= f.bit_valid ? sh_in : sh_r;
			rw_r <= rw_nxt;
			addr_r <= addr_nxt;
			start_r <= start_nxt;
			idx_r <= idx_nxt;
			held_r <= held_nxt;
			tx_r <= tx_nxt;
			sdo_r <= sdo_nxt;
			oe_r <= oe_nxt;
			mb_pend_r <= mb_pend_nxt;
			mb_addr_r <= mb_addr_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			style_r <= CFG_B_RST;
			wrap_r <= WRAP_RST;
			ctrl_r <= CTRL_RST; // [R12]
			flags_r <= FLAGS_RST;
			interr_r <= 1'b0;
		end
		else
		begin
			style_r <= style_nxt;
			wrap_r <= wrap_nxt;
			ctrl_r <= ctrl_nxt;
			flags_r <= flags_nxt;
			interr_r <= |flags_nxt; // [R14]
		end
	end

	// interface stays deaf for a fixed time after reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdy_cnt_r <= 8'h00;
			ready_r <= 1'b0;
		end
		else
		begin
			rdy_cnt_r <= ready_r ? rdy_cnt_r : (rdy_cnt_r + 8'h01);
			ready_r <= ready_r || ((rdy_cnt_r + 8'h01) == READY_CYC);
		end
	end

	assign sdo = sdo_r;
	assign sdo_oe = oe_r;
	assign interface_error = interr_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_early;
		f.frame_start && !ready_r;
	endsequence
	sequence s_stream_step;
		adv && !style_r;
	endsequence

	property p_no_wrap;
		s_stream_step ##0 (wrap_r == 8'h00) |=> addr_r == ($past(addr_r) + 15'h0001);
	endproperty
	a_no_wrap: assert property (p_no_wrap) else $error("address did not advance"); // [R1]
	property p_wrap;
		s_stream_step ##0 wrap_hit |=> (addr_r == $past(start_r)) && (idx_r == 8'h00);
	endproperty
	a_wrap: assert property (p_wrap) else $error("loop did not return to start"); // [R2]
	property p_crc_gate;
		(ctrl_r[CRC_EN_MSB:CRC_EN_LSB] != CRC_EN_ON) |=> state_r != ST_CHK;
	endproperty
	a_crc_gate: assert property (p_crc_gate) else $error("checksum phase while disabled"); // [R3]
	property p_reset_defaults;
		$past(!rst_b) |-> (ctrl_r == CTRL_RST) && !crc_on && (flags_r == FLAGS_RST);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset value"); // [R12]
	property p_not_ready;
		s_early |=> flags_r[F_NOT_RDY] && (state_r == ST_DROP);
	endproperty
	a_not_ready: assert property (p_not_ready) else $error("early frame not flagged"); // [R5]
	property p_sck;
		f.frame_end && (state_r == ST_INSTR) && (icnt_r != 4'h0) |=> flags_r[F_SCK];
	endproperty
	a_sck: assert property (p_sck) else $error("short frame not flagged"); // [R6]
	property p_crc_only;
		$rose(flags_r[F_CRC]) |-> $past(crc_on);
	endproperty
	a_crc_only: assert property (p_crc_only) else $error("checksum flag while disabled"); // [R7]
	property p_ro;
		err_ro |=> flags_r[F_WR_RO];
	endproperty
	a_ro: assert property (p_ro) else $error("read-only write not flagged"); // [R8]
	property p_part;
		$rose(flags_r[F_PART]) |-> $past(strict);
	endproperty
	a_part: assert property (p_part) else $error("partial flag while not strict"); // [R9]
	property p_addr;
		instr_done && (in_addr > ADDR_MAX) |=> flags_r[F_ADDR];
	endproperty
	a_addr: assert property (p_addr) else $error("bad address not flagged"); // [R10]
	property p_single;
		adv && style_r && !f.frame_end |=> (state_r == ST_INSTR) && (icnt_r == 4'h0);
	endproperty
	a_single: assert property (p_single) else $error("single mode did not re-instruct"); // [R13]
	property p_summary;
		interface_error == (|flags_r);
	endproperty
	a_summary: assert property (p_summary) else $error("summary differs from flags"); // [R14]
endmodule

// ==== testbench/sic_host_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// serial host: mode 0, msb first, sck idle low between frames
module sic_host_model (
	// clock
	input wire logic clk,
	// serial link
	output logic sck,
	output logic cs_b,
	output logic sdi,
	input wire logic sdo
);
	initial
	begin
		sck = 1'b0;
		cs_b = 1'b1;
		sdi = 1'b0;
	end

	// ==========================================================
	// bit and byte shifting
	// sdo taken just before the rise, five and a half clock cycles after it last moved
	task automatic bit1(input logic b, output logic r);
		@(negedge clk);
		sdi = b;
		repeat (3) @(negedge clk);
		r = sdo;
		sck = 1'b1;
		repeat (4) @(negedge clk);
		sck = 1'b0;
	endtask
	task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			bit1(w[i], r[i]);
	endtask
	task automatic xinst(input logic [15:0] w);
		logic [7:0] d;
		xbyte(w[15:8], d);
		xbyte(w[7:0], d);
	endtask

	// ==========================================================
	// framing
	task automatic open_frame();
		@(negedge clk);
		cs_b = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	// released data line flips so a stale level never looks valid
	task automatic close_frame();
		repeat (4) @(negedge clk);
		cs_b = 1'b1;
		sdi = ~sdi;
		repeat (12) @(negedge clk);
	endtask

	// ==========================================================
	// register frames
	task automatic wr1(input logic [14:0] a, input logic [7:0] w, input logic ck,
		input logic [7:0] cv);
		logic [7:0] d;
		open_frame();
		xinst({1'b0, a});
		xbyte(w, d);
		if (ck)
			xbyte(cv, d);
		close_frame();
	endtask
	task automatic rd1(input logic [14:0] a, input logic ck, output logic [7:0] r,
		output logic [7:0] c);
		open_frame();
		xinst({1'b1, a});
		xbyte(8'h00, r);
		c = 8'h00;
		if (ck)
			xbyte(8'h00, c);
		close_frame();
	endtask
	// wide register: even then odd byte in one data phase
	task automatic wr2(input logic [14:0] a, input logic [15:0] w);
		logic [7:0] d;
		open_frame();
		xinst({1'b0, a});
		xbyte(w[15:8], d);
		xbyte(w[7:0], d);
		close_frame();
	endtask
endmodule

// ==== testbench/sic_config_status_tb_top.sv ====
`timescale 1ns/10ps
module sic_config_status_tb_top;
	import sic_pkg::*;
	logic clk;
	logic rst_b;
	logic sck;
	logic cs_b;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic interface_error;
	logic crc_on;
	logic [7:0] bad;
	int err_count;
	int n_checks;
	int cyc;
	// about 13k cycles expected
	localparam int CYC_MAX = 40000;

	sic_config_status sic_config_status_i (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .interface_error(interface_error));
	sic_host_model sic_host_model_i (.clk(clk), .sck(sck), .cs_b(cs_b), .sdi(sdi), .sdo(sdo));

	// ==========================================================
	// clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == CYC_MAX)
		begin
			err_count++;
			final_report();
		end
	end

	// ==========================================================
	// helpers
	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0] c;
		c = d;
		repeat (8)
			c = {c[6:0], 1'b0} ^ (c[7] ? CRC_POLY : 8'h00);
		return c;
	endfunction
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] w);
		sic_host_model_i.wr1(a, w, crc_on, crc8(w) ^ bad);
	endtask
	task automatic rdc(input logic [14:0] a, input logic [7:0] e);
		logic [7:0] r;
		logic [7:0] c;
		sic_host_model_i.rd1(a, crc_on, r, c);
		chk8(r, e);
		if (crc_on)
			chk8(c, crc8(r));
	endtask
	task automatic ie(input logic e);
		chk8({7'h00, interface_error}, {7'h00, e});
	endtask
	task automatic oe(input logic e);
		chk8({7'h00, sdo_oe}, {7'h00, e});
	endtask
	// four-byte streaming read
	task automatic srd(input logic [14:0] a, input logic [31:0] e);
		logic [7:0] d;
		sic_host_model_i.open_frame();
		sic_host_model_i.xinst({1'b1, a});
		for (int i = 0; i < 4; i++)
		begin
			sic_host_model_i.xbyte(8'h00, d);
			chk8(d, e[31 - 8 * i -: 8]);
		end
		sic_host_model_i.close_frame();
	endtask

	// ==========================================================
	// scenarios
	task automatic t_ready();
		logic [7:0] d;
		sic_host_model_i.open_frame();
		sic_host_model_i.xinst({1'b0, OFS_WRAP});
		sic_host_model_i.xbyte(8'h77, d);
		sic_host_model_i.close_frame();
		repeat (300) @(negedge clk);
		rdc(OFS_FLAGS, 8'h80);
		ie(1'b1);
		wr(OFS_FLAGS, 8'h80);
		rdc(OFS_FLAGS, 8'h00);
		ie(1'b0);
		rdc(OFS_WRAP, WRAP_RST);
		$display("t_ready done");
	endtask
	task automatic t_reset();
		rdc(OFS_CTRL, CTRL_RST);
		rdc(OFS_CFG_B, 8'h00);
		rdc(OFS_MAKER_HI, MAKER_CODE[15:8]);
		rdc(OFS_MAKER_LO, MAKER_CODE[7:0]);
		wr(OFS_CTRL, 8'hff);
		rdc(OFS_CTRL, 8'he3);
		wr(OFS_WRAP, 8'h33);
		rdc(OFS_WRAP, 8'h33);
		wr(OFS_CTRL, CTRL_RST);
		wr(OFS_FLAGS, 8'h60);
		rdc(OFS_FLAGS, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_errors();
		logic b;
		wr(OFS_MAKER_HI, 8'h00);
		rdc(OFS_MAKER_HI, MAKER_CODE[15:8]);
		rdc(15'h0180, 8'h00);
		rdc(OFS_FLAGS, 8'h05);
		wr(OFS_FLAGS, 8'h05);
		sic_host_model_i.open_frame();
		sic_host_model_i.xinst({1'b1, OFS_WRAP});
		repeat (3) sic_host_model_i.bit1(1'b0, b);
		sic_host_model_i.close_frame();
		rdc(OFS_FLAGS, 8'h10);
		ie(1'b1);
		wr(OFS_FLAGS, 8'h00);
		rdc(OFS_FLAGS, 8'h00);
		$display("t_errors done");
	endtask
	task automatic t_wrap();
		wr(OFS_WRAP, 8'h00);
		srd(OFS_MAKER_LO, {MAKER_CODE[7:0], MAKER_CODE[15:8], 16'h0000});
		wr(OFS_WRAP, 8'h02);
		srd(OFS_MAKER_LO, {MAKER_CODE[7:0], MAKER_CODE[15:8], MAKER_CODE[7:0],
			MAKER_CODE[15:8]});
		wr(OFS_WRAP, 8'h00);
		$display("t_wrap done");
	endtask
	task automatic t_single();
		logic [7:0] d;
		wr(OFS_CFG_B, 8'h80);
		sic_host_model_i.open_frame();
		sic_host_model_i.xinst({1'b1, OFS_MAKER_HI});
		oe(1'b1);
		sic_host_model_i.xbyte(8'h00, d);
		chk8(d, MAKER_CODE[15:8]);
		oe(1'b0);
		sic_host_model_i.xinst({1'b1, OFS_MAKER_LO});
		sic_host_model_i.xbyte(8'h00, d);
		chk8(d, MAKER_CODE[7:0]);
		sic_host_model_i.xinst({1'b0, OFS_CFG_B});
		sic_host_model_i.xbyte(8'h00, d);
		sic_host_model_i.close_frame();
		rdc(OFS_CFG_B, 8'h00);
		$display("t_single done");
	endtask
	task automatic t_wide();
		wr(MB_FIRST, 8'h11);
		rdc(OFS_FLAGS, 8'h02);
		wr(OFS_FLAGS, 8'h02);
		sic_host_model_i.wr2(MB_FIRST, 16'h1122);
		rdc(OFS_FLAGS, 8'h00);
		wr(OFS_CTRL, 8'h03);
		wr(MB_FIRST, 8'h11);
		rdc(OFS_FLAGS, 8'h00);
		wr(OFS_CTRL, CTRL_RST);
		$display("t_wide done");
	endtask
	task automatic t_crc();
		wr(OFS_CTRL, 8'h62);
		crc_on = 1'b1;
		bad = 8'h5a;
		wr(OFS_WRAP, 8'h44);
		bad = 8'h00;
		rdc(OFS_FLAGS, 8'h08);
		rdc(OFS_WRAP, 8'h00);
		wr(OFS_FLAGS, 8'h08);
		wr(OFS_WRAP, 8'h44);
		rdc(OFS_WRAP, 8'h44);
		wr(OFS_WRAP, 8'h00);
		wr(OFS_CTRL, CTRL_RST);
		crc_on = 1'b0;
		rdc(OFS_CTRL, CTRL_RST);
		rdc(OFS_FLAGS, 8'h00);
		$display("t_crc done");
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		rst_b = 1'b0;
		crc_on = 1'b0;
		bad = 8'h00;
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		t_ready();
		t_reset();
		t_errors();
		t_wrap();
		t_single();
		t_wide();
		t_crc();
		final_report();
	end
endmodule
